// ==== design/sbs_status_top.sv ====
// Purpose: Register port, transmit and receive flags, mode fault and master clock control.
// Assumes: Shift engine shares ref_clk and reports each finished byte with xferDone.
// Notes: Slave-select and the incoming serial clock are pins and are synchronised here.
//
// Local design decision: the address-and-strobe port.

`timescale 1ns/10ps

module sbs_status_top
  import sbs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Register port
  input wire sbs_bus_req_t busReq,
  output logic [DATA_W-1:0] rdData,
  // Shift engine
  input wire logic xferDone,
  input wire logic [DATA_W-1:0] rxByte,
  output sbs_eng_ctl_t engCtl,
  output logic sckInEdge,
  // Serial pins
  input wire logic ssIn,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  output logic serialOe,
  output logic ssOut,
  output logic ssOe,
  // Interrupt
  output logic irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [DATA_W-1:0] ctrlOne_reg;
  logic [DATA_W-1:0] ctrlTwo_reg;
  logic [DATA_W-1:0] clkDiv_reg;
  logic [DATA_W-1:0] txBuf_reg;
  logic [DATA_W-1:0] rxData_reg;
  logic rxFull_reg;
  logic txEmpty_reg;
  logic fault_reg;
  logic rxArm_reg;
  logic txArm_reg;
  logic faultArm_reg;
  logic [EVT_W-1:0] evtStat_reg;
  logic [EVT_W-1:0] evtMask_reg;
  logic [1:0] ssSync_reg;
  logic [1:0] sckSync_reg;
  logic sckPrev_reg;
  logic ssPrev_reg;
  sbs_xfer_state_t state_reg;
  sbs_xfer_state_t state_next;

  logic isMaster;
  logic faultEvent;
  logic cfgChange;
  logic abortNow;
  logic statusRd;
  logic dataRd;
  logic dataWr;
  logic ctrlOneWr;
  logic txAccept;
  logic xferStart;
  logic slaveFrameStart;
  logic genRun;
  logic genDone;
  logic genSck;
  logic [DATA_W-1:0] flagsView;
  logic [EVT_W-1:0] evtSet;

  function automatic logic hit(input sbs_bus_req_t r, input logic [ADDR_W-1:0] ofs);
    hit = r.addr == ofs;
  endfunction

  assign statusRd = busReq.rd && hit(busReq, OFS_FLAGS);
  assign dataRd = busReq.rd && hit(busReq, OFS_DATA);
  assign dataWr = busReq.wr && hit(busReq, OFS_DATA);
  assign ctrlOneWr = busReq.wr && hit(busReq, OFS_CTRL_ONE);
  assign isMaster = ctrlOne_reg[BIT_MASTER];

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ssSync_reg <= 2'h3;
      sckSync_reg <= 2'h0;
    end else begin
      ssSync_reg <= {ssSync_reg[0], ssIn};
      sckSync_reg <= {sckSync_reg[0], sckIn};
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sckPrev_reg <= 1'b0;
      ssPrev_reg <= 1'b1;
      sckInEdge <= 1'b0;
    end else begin
      sckPrev_reg <= sckSync_reg[1];
      ssPrev_reg <= ssSync_reg[1];
      sckInEdge <= !isMaster && !ssSync_reg[1] && (sckPrev_reg != sckSync_reg[1]);
    end
  end

  // Detection only looks at the select input when it is not driven as an output.
  assign faultEvent = isMaster && ctrlTwo_reg[BIT_FAULT_EN] && !ctrlOne_reg[BIT_SS_OUT_EN]
                      && !ssSync_reg[1];
  assign slaveFrameStart = !isMaster && ssPrev_reg && !ssSync_reg[1];

  // ****************************************************************
  // Abort conditions
  // ****************************************************************
  // Any configuration change in master mode idles the port; the far slave
  // cannot see this, so software must bring it back to idle itself.
  always_comb begin
    cfgChange = 1'b0;
    if (busReq.wr && hit(busReq, OFS_CLK_DIV)) begin
      cfgChange = (busReq.wdata & CLK_DIV_MASK) != clkDiv_reg;
    end else if (ctrlOneWr) begin
      cfgChange = busReq.wdata != ctrlOne_reg;
    end else if (busReq.wr && hit(busReq, OFS_CTRL_TWO)) begin
      cfgChange = (busReq.wdata & CTRL_TWO_MASK) != ctrlTwo_reg;
    end
  end

  assign abortNow = (isMaster && cfgChange) || faultEvent;

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlOne_reg <= CTRL_ONE_RST;
    end else if (faultEvent) begin
      ctrlOne_reg[BIT_MASTER] <= 1'b0;
    end else if (ctrlOneWr) begin
      ctrlOne_reg <= busReq.wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlTwo_reg <= CTRL_TWO_RST;
    end else if (busReq.wr && hit(busReq, OFS_CTRL_TWO)) begin
      ctrlTwo_reg <= busReq.wdata & CTRL_TWO_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      clkDiv_reg <= CLK_DIV_RST;
    end else if (busReq.wr && hit(busReq, OFS_CLK_DIV)) begin
      clkDiv_reg <= busReq.wdata & CLK_DIV_MASK;
    end
  end

  // ****************************************************************
  // Transmit side
  // ****************************************************************
  assign txAccept = dataWr && txArm_reg;
  assign xferStart = (state_reg == XFER_IDLE) && isMaster && !txEmpty_reg && !abortNow;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      txArm_reg <= 1'b0;
    end else if (dataWr) begin
      txArm_reg <= 1'b0;
    end else if (statusRd && txEmpty_reg) begin
      txArm_reg <= 1'b1;
    end
  end

  // The buffer drains into the shift engine when a master transfer starts or
  // a slave frame opens, so one byte can wait while another shifts.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      txEmpty_reg <= 1'b1;
      txBuf_reg <= '0;
    end else if (txAccept) begin
      txEmpty_reg <= 1'b0;
      txBuf_reg <= busReq.wdata;
    end else if (xferStart || (slaveFrameStart && !txEmpty_reg)) begin
      txEmpty_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // Master transfer sequencing
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      XFER_IDLE: begin
        if (xferStart) begin
          state_next = XFER_RUN;
        end
      end
      XFER_RUN: begin
        if (abortNow || genDone || !isMaster) begin
          state_next = XFER_IDLE;
        end
      end
      default: begin
        state_next = XFER_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= XFER_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign genRun = (state_reg == XFER_RUN) && (state_next == XFER_RUN);

  sbs_baud_gen #(
    .CW(CNT_W)
  ) u_baud (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .preselect(clkDiv_reg[PRE_MSB:PRE_LSB]),
    .powerSelect(clkDiv_reg[POW_MSB:POW_LSB]),
    .run(genRun),
    .sckLevel(genSck),
    .byteDone(genDone)
  );

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      engCtl <= '0;
    end else begin
      engCtl.start <= xferStart || (slaveFrameStart && !txEmpty_reg);
      engCtl.abort <= (state_reg == XFER_RUN) && abortNow;
      engCtl.master <= isMaster && !faultEvent;
      if (xferStart || slaveFrameStart) begin
        engCtl.txByte <= txBuf_reg;
      end
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sckOut <= 1'b0;
      sckOe <= 1'b0;
      serialOe <= 1'b0;
      ssOut <= 1'b1;
      ssOe <= 1'b0;
    end else begin
      sckOut <= genSck;
      sckOe <= isMaster && !faultEvent;
      // In slave mode a pending mode fault keeps the data outputs off until software services it.
      serialOe <= isMaster ? !faultEvent : (!ssSync_reg[1] && !fault_reg);
      ssOut <= !genRun;
      ssOe <= isMaster && ctrlTwo_reg[BIT_FAULT_EN] && ctrlOne_reg[BIT_SS_OUT_EN];
    end
  end

  // ****************************************************************
  // Receive side
  // ****************************************************************
  // An unread byte is kept; later bytes are lost until the flag is serviced.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxData_reg <= '0;
    end else if (xferDone && !rxFull_reg) begin
      rxData_reg <= rxByte;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxArm_reg <= 1'b0;
    end else if (dataRd) begin
      rxArm_reg <= 1'b0;
    end else if (statusRd && rxFull_reg) begin
      rxArm_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxFull_reg <= 1'b0;
    end else if (xferDone) begin
      rxFull_reg <= 1'b1;
    end else if (dataRd && rxArm_reg) begin
      rxFull_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Mode fault flag
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      faultArm_reg <= 1'b0;
    end else if (ctrlOneWr) begin
      faultArm_reg <= 1'b0;
    end else if (statusRd && fault_reg) begin
      faultArm_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_reg <= 1'b0;
    end else if (faultEvent) begin
      fault_reg <= 1'b1;
    end else if (ctrlOneWr && faultArm_reg) begin
      fault_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Interrupt events
  // ****************************************************************
  assign evtSet[EVT_RX] = xferDone;
  assign evtSet[EVT_TX] = xferStart;
  assign evtSet[EVT_FAULT] = faultEvent;

  // A new event in the same cycle as its write-one clear stays set.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      evtStat_reg <= '0;
    end else begin
      evtStat_reg <= evtSet | (evtStat_reg &
        ~((busReq.wr && hit(busReq, OFS_EVT_STAT)) ? busReq.wdata[EVT_W-1:0] : '0));
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      evtMask_reg <= '0;
    end else if (busReq.wr && hit(busReq, OFS_EVT_MASK)) begin
      evtMask_reg <= busReq.wdata[EVT_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= (|(evtStat_reg & evtMask_reg))
             || (ctrlOne_reg[BIT_INT_EN] && (fault_reg || rxFull_reg));
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_comb begin
    flagsView = '0;
    flagsView[FLAG_RX_FULL] = rxFull_reg;
    flagsView[FLAG_TX_EMPTY] = txEmpty_reg;
    flagsView[FLAG_FAULT] = fault_reg;
  end

  // Writes to the flag register have no decode at all, so they change nothing.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData <= '0;
    end else if (busReq.rd) begin
      case (busReq.addr)
        OFS_CTRL_ONE: rdData <= ctrlOne_reg;
        OFS_CTRL_TWO: rdData <= ctrlTwo_reg;
        OFS_CLK_DIV: rdData <= clkDiv_reg;
        OFS_FLAGS: rdData <= flagsView;
        OFS_DATA: rdData <= rxData_reg;
        OFS_EVT_STAT: rdData <= DATA_W'(evtStat_reg);
        OFS_EVT_MASK: rdData <= DATA_W'(evtMask_reg);
        default: rdData <= '0;
      endcase
    end else begin
      rdData <= '0;
    end
  end

endmodule

// ==== design/sbs_pkg.sv ====
// Purpose: Shared constants and types for the serial port baud and status block.
// Assumes: Byte-wide register port on a single 125 MHz clock.
// Notes: Offsets are register indices on the plain register port.
//
// Behaviour
// - Divisor equals (preselect plus one) times two to the (power select plus one).
// - Master serial clock is bus clock divided by divisor, 2 up to 2048.
// - In master mode a divisor field change aborts the transfer and idles the port.
// - Divisor register reads and writes anytime; unused bits stay zero.
// - Flag register reads anytime; writes to it change nothing.
// - Receive-full flag, status bit 7, sets when a received byte reaches data register.
// - Receive-full clears after a status read seeing it set, then a data read.
// - Status bit 5 shows transmit data register empty when one.
// - Status read seeing transmit-empty, then data write, queues byte and clears flag.
// - A data write without that prior status read is discarded.
// - Mode-fault flag, bit 4, sets on select low while master with detection on.
// - Mode-fault clears after a status read seeing it, then a control one write.
// - Mode fault drops master bit, disables serial outputs, aborts and idles.
// - Interrupt is requested when mode fault sets with port interrupt enable on.
// - After a master data write, wait half a serial clock before clocking.

package sbs_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int CNT_W = 11;
  localparam int EDGE_W = 5;

  // ****************************************************************
  // Register indices
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL_ONE = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL_TWO = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_CLK_DIV = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_DATA = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_EVT_STAT = 3'h6;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 3'h7;

  // ****************************************************************
  // Field positions, masks and reset values
  // ****************************************************************
  localparam int BIT_INT_EN = 7;
  localparam int BIT_MASTER = 4;
  localparam int BIT_SS_OUT_EN = 1;
  localparam int BIT_FAULT_EN = 4;
  localparam int PRE_MSB = 6;
  localparam int PRE_LSB = 4;
  localparam int POW_MSB = 2;
  localparam int POW_LSB = 0;
  localparam int FLAG_RX_FULL = 7;
  localparam int FLAG_TX_EMPTY = 5;
  localparam int FLAG_FAULT = 4;
  localparam int EVT_RX = 0;
  localparam int EVT_TX = 1;
  localparam int EVT_FAULT = 2;
  localparam int EVT_W = 3;

  localparam logic [DATA_W-1:0] CTRL_ONE_RST = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_TWO_RST = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_TWO_MASK = 8'h1b;
  localparam logic [DATA_W-1:0] CLK_DIV_RST = 8'h00;
  localparam logic [DATA_W-1:0] CLK_DIV_MASK = 8'h77;
  localparam logic [EDGE_W-1:0] EDGES_PER_BYTE = 5'h10;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } sbs_bus_req_t;

  typedef struct packed {
    logic start;
    logic abort;
    logic master;
    logic [DATA_W-1:0] txByte;
  } sbs_eng_ctl_t;

  typedef enum logic [0:0] {
    XFER_IDLE,
    XFER_RUN
  } sbs_xfer_state_t;

endpackage

// ==== design/sbs_baud_gen.sv ====
// Purpose: Serial clock generator dividing the bus clock by the programmed divisor.
// Assumes: run is a level from the same clock domain.
// Notes: Counts its own clock edges and pulses done after a full byte.

`timescale 1ns/10ps

module sbs_baud_gen
  import sbs_pkg::*;
#(
  parameter int CW = CNT_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Divisor fields
  input wire logic [2:0] preselect,
  input wire logic [2:0] powerSelect,
  // Control and results
  input wire logic run,
  output logic sckLevel,
  output logic byteDone
);

  logic [CW-1:0] halfDiv;
  logic [CW-1:0] cnt_reg;
  logic [EDGE_W-1:0] edges_reg;

  // Half the divisor: (pre+1) * 2^pow, so a full period is (pre+1) * 2^(pow+1).
  assign halfDiv = CW'(({{(CW-3){1'b0}}, preselect} + CW'(1)) << powerSelect);

  // ****************************************************************
  // Half-period counter
  // ****************************************************************
  // The first toggle comes a full half period after run rises, which gives
  // the lead-in delay before the first serial clock edge.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
      sckLevel <= 1'b0;
      edges_reg <= '0;
    end else if (!run) begin
      cnt_reg <= halfDiv - CW'(1);
      sckLevel <= 1'b0;
      edges_reg <= '0;
    end else if (cnt_reg == '0) begin
      cnt_reg <= halfDiv - CW'(1);
      sckLevel <= ~sckLevel;
      edges_reg <= edges_reg + EDGE_W'(1);
    end else begin
      cnt_reg <= cnt_reg - CW'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      byteDone <= 1'b0;
    end else begin
      byteDone <= run && (cnt_reg == '0) && (edges_reg == EDGES_PER_BYTE - EDGE_W'(1));
    end
  end

endmodule

// ==== verif/sbs_status_props.sv ====
// Purpose: Port-level assertions for the baud and status block.
// Assumes: Control fields are followed through shadow copies of bus writes.
// Notes: Bound to every instance of the top module.
`timescale 1ns/10ps
module sbs_status_props
  import sbs_pkg::*;
(
  // Clock, reset and register port
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire sbs_bus_req_t busReq,
  input wire logic [DATA_W-1:0] rdData,
  // Engine, pins and interrupt
  input wire sbs_eng_ctl_t engCtl,
  input wire logic ssIn,
  input wire logic sckOut,
  input wire logic sckOe,
  input wire logic ssOut,
  input wire logic irq
);
  // ****************
  // Shadow state
  // ****************
  logic [DATA_W-1:0] div_reg, ctlA_reg, ctlB_reg;
  logic flagRd_reg, arm_reg, pend_reg, sckPrev_reg, quiet_reg;
  logic [CNT_W-1:0] gap_reg, start_reg, halfDiv;
  logic [EDGE_W-1:0] tog_reg;
  wire logic divWr = busReq.wr && busReq.addr == OFS_CLK_DIV;
  wire logic dataWr = busReq.wr && busReq.addr == OFS_DATA;
  wire logic armNow = flagRd_reg && rdData[FLAG_TX_EMPTY];
  wire logic tgl = sckOut != sckPrev_reg;
  assign halfDiv = CNT_W'(div_reg[PRE_MSB:PRE_LSB] + 4'h1) << div_reg[POW_MSB:POW_LSB];

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= CLK_DIV_RST;
      ctlA_reg <= CTRL_ONE_RST;
      ctlB_reg <= CTRL_TWO_RST;
    end else if (busReq.wr) begin
      if (divWr) div_reg <= busReq.wdata & CLK_DIV_MASK;
      if (busReq.addr == OFS_CTRL_ONE) ctlA_reg <= busReq.wdata;
      if (busReq.addr == OFS_CTRL_TWO) ctlB_reg <= busReq.wdata & CTRL_TWO_MASK;
    end
  end

  // A divider write mid-run may abort, so timing checks wait for the next start.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flagRd_reg <= 1'b0;
      arm_reg <= 1'b0;
      pend_reg <= 1'b0;
      quiet_reg <= 1'b0;
      start_reg <= '0;
    end else begin
      flagRd_reg <= busReq.rd && busReq.addr == OFS_FLAGS;
      arm_reg <= dataWr ? 1'b0 : (arm_reg || armNow);
      pend_reg <= (dataWr && (arm_reg || armNow)) || (pend_reg && !engCtl.start);
      quiet_reg <= divWr || (quiet_reg && !engCtl.start);
      if (engCtl.start) start_reg <= CNT_W'(1);
      else if (start_reg != '1) start_reg <= start_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sckPrev_reg <= 1'b0;
      gap_reg <= '0;
      tog_reg <= '0;
    end else begin
      sckPrev_reg <= sckOut;
      gap_reg <= tgl ? CNT_W'(1) : gap_reg + 1'b1;
      tog_reg <= ssOut ? '0 : tog_reg + EDGE_W'(tgl);
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  property p_rd_quiet;
    !$past(busReq.rd) |-> rdData == '0;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read slot");
  property p_half;
    tgl && tog_reg != '0 && !ssOut && !quiet_reg |-> gap_reg == halfDiv;
  endproperty
  a_half: assert property (p_half) else $error("serial clock half period wrong");
  property p_first;
    tgl && tog_reg == '0 && !ssOut && !quiet_reg |-> start_reg + 1 >= halfDiv
      && start_reg <= halfDiv + 4;
  endproperty
  a_first: assert property (p_first) else $error("first serial edge mistimed");
  property p_idle_low;
    ssOut && $past(ssOut) |-> !sckOut;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("serial clock moves while idle");
  property p_abort;
    divWr && (busReq.wdata & CLK_DIV_MASK) != div_reg && engCtl.master && !ssOut
      |-> ##[1:3] engCtl.abort ##[0:3] ssOut;
  endproperty
  a_abort: assert property (p_abort) else $error("divider change did not abort");
  property p_no_clk;
    !engCtl.master [*2] |-> !sckOe;
  endproperty
  a_no_clk: assert property (p_no_clk) else $error("clock driven while slave");
  property p_fault;
    (engCtl.master && ctlB_reg[BIT_FAULT_EN] && !ctlA_reg[BIT_SS_OUT_EN] && !ssIn) [*4]
      |-> ##[0:3] !engCtl.master;
  endproperty
  a_fault: assert property (p_fault) else $error("select low did not drop master");
  property p_irq;
    $fell(engCtl.master) && ctlA_reg[BIT_INT_EN] && ctlB_reg[BIT_FAULT_EN]
      && !ctlA_reg[BIT_SS_OUT_EN] && !ssIn |-> ##[0:3] irq;
  endproperty
  a_irq: assert property (p_irq) else $error("mode fault raised no interrupt");
  property p_start;
    engCtl.start |-> pend_reg;
  endproperty
  a_start: assert property (p_start) else $error("start without queued byte");
endmodule

bind sbs_status_top sbs_status_props sbs_status_props_inst (
  .ref_clk(ref_clk), .arst_n(arst_n), .busReq(busReq), .rdData(rdData), .engCtl(engCtl),
  .ssIn(ssIn), .sckOut(sckOut), .sckOe(sckOe), .ssOut(ssOut), .irq(irq)
);

// ==== verif/sbs_far_master.sv ====
// Purpose: Far master on the link: drives select and serial clock for one frame.
// Assumes: A rising go opens a frame.
// Notes: Select idles high as if pulled up; the clock stands at 0 outside frames.
`timescale 1ns/10ps
module sbs_far_master #(
  parameter int EDGES = 16,
  parameter int HALF_NS = 40
) (
  // Frame request
  input wire logic go,
  // Link pins
  output logic ssN,
  output logic sck
);
  initial begin
    ssN = 1'b1;
    sck = 1'b0;
  end
  // An 80 ns period keeps the link far slower than divide-by-two of the bus clock.
  always @(posedge go) begin
    ssN = 1'b0;
    #(HALF_NS);
    repeat (EDGES) #(HALF_NS) sck = ~sck;
    #(HALF_NS) ssN = 1'b1;
  end
endmodule

// ==== verif/sbs_status_top_tb.sv ====
// Purpose: Self-checking bench for the baud and status block.
// Assumes: The bench stands in for the shift engine and for software.
// Notes: A far master model drives the select and serial clock pins.
`timescale 1ns/10ps
module sbs_status_top_tb
  import sbs_pkg::*;
;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  sbs_bus_req_t busReq = '0;
  logic xferDone = 1'b0;
  logic [DATA_W-1:0] rxByte = '0;
  logic farGo = 1'b0;
  logic [DATA_W-1:0] rdData;
  sbs_eng_ctl_t engCtl;
  logic sckInEdge, ssIn, sckIn, sckOut, sckOe, serialOe, ssOut, ssOe, irq;
  int miscompares = 0;
  int cmp_count = 0;
  int k, span, ab, n;

  always #4 ref_clk = ~ref_clk;

  sbs_status_top sbs_status_top_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .busReq(busReq), .rdData(rdData),
    .xferDone(xferDone), .rxByte(rxByte), .engCtl(engCtl), .sckInEdge(sckInEdge),
    .ssIn(ssIn), .sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe), .serialOe(serialOe),
    .ssOut(ssOut), .ssOe(ssOe), .irq(irq)
  );
  sbs_far_master sbs_far_master_inst (.go(farGo), .ssN(ssIn), .sck(sckIn));

  // ****************
  // Helpers
  // ****************
  task automatic tally_and_finish;
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [15:0] exp, input logic [15:0] act);
    cmp_count++;
    if (act !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    if (busReq.wr || busReq.rd) tick(1);
    busReq.addr <= a;
    busReq.wdata <= d;
    busReq.wr <= 1'b1;
    tick(1);
    busReq.wr <= 1'b0;
  endtask
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    if (busReq.wr || busReq.rd) tick(1);
    busReq.addr <= a;
    busReq.rd <= 1'b1;
    tick(1);
    busReq.rd <= 1'b0;
    check(exp, rdData);
  endtask
  task automatic rxPulse(input logic [DATA_W-1:0] v);
    rxByte <= v;
    xferDone <= 1'b1;
    tick(1);
    xferDone <= 1'b0;
  endtask
  // Counts clock toggles and abort pulses over a fixed window.
  task automatic watch(input int cyc);
    logic prev;
    int first;
    prev = sckOut;
    first = 0;
    k = 0;
    span = 0;
    ab = 0;
    for (int c = 0; c < cyc; c++) begin
      if (engCtl.abort === 1'b1) ab++;
      tick(1);
      if (sckOut !== prev) begin
        if (k == 0) first = c;
        span = c - first;
        k++;
      end
      prev = sckOut;
    end
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_regs;
    rc(OFS_FLAGS, 8'h20);
    rc(OFS_CLK_DIV, CLK_DIV_RST);
    wr(OFS_CLK_DIV, 8'hff);
    rc(OFS_CLK_DIV, 8'h77);
    wr(OFS_FLAGS, 8'hff);
    rc(OFS_FLAGS, 8'h20);
    rc(3'h4, 8'h00);
  endtask
  task automatic t_rx;
    rxPulse(8'ha5);
    rc(OFS_DATA, 8'ha5);
    rc(OFS_FLAGS, 8'ha0);
    rxPulse(8'h3c);
    rc(OFS_DATA, 8'ha5);
    rc(OFS_FLAGS, 8'h20);
    wr(OFS_EVT_MASK, 8'h01);
    tick(2);
    check(1, irq);
    wr(OFS_EVT_STAT, 8'h07);
    tick(2);
    check(0, irq);
    wr(OFS_EVT_MASK, 8'h00);
  endtask
  task automatic t_tx;
    wr(OFS_CLK_DIV, 8'h21);
    wr(OFS_CTRL_ONE, 8'h10);
    rc(OFS_FLAGS, 8'h20);
    wr(OFS_DATA, 8'h5a);
    n = 0;
    while (engCtl.start !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    if (n == 20) miscompares++;
    if (n == 20) tally_and_finish();
    check(8'h5a, engCtl.txByte);
    watch(200);
    check(16, k);
    check(90, span);
    check(1, ssOut);
    wr(OFS_DATA, 8'hc3);
    watch(40);
    check(0, k);
  endtask
  task automatic t_abort;
    rc(OFS_FLAGS, 8'h20);
    wr(OFS_DATA, 8'h3c);
    tick(20);
    wr(OFS_CLK_DIV, 8'h21);
    watch(200);
    check(0, ab);
    rc(OFS_FLAGS, 8'h20);
    wr(OFS_DATA, 8'h96);
    tick(20);
    wr(OFS_CLK_DIV, 8'h20);
    watch(10);
    check(1, ab);
    check(1, ssOut);
  endtask
  task automatic t_fault;
    wr(OFS_CTRL_TWO, 8'h10);
    wr(OFS_CTRL_ONE, 8'h12);
    tick(1);
    check(1, ssOe);
    wr(OFS_CTRL_ONE, 8'h90);
    farGo <= 1'b1;
    tick(8);
    check(0, engCtl.master);
    check(0, serialOe);
    check(1, irq);
    wr(OFS_CTRL_ONE, 8'h80);
    rc(OFS_FLAGS, 8'h30);
    wr(OFS_CTRL_ONE, 8'h80);
    rc(OFS_FLAGS, 8'h20);
    tick(2);
    check(0, irq);
    n = 0;
    while (ssIn !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    if (n == 200) miscompares++;
    if (n == 200) tally_and_finish();
    farGo <= 1'b0;
    tick(2);
    farGo <= 1'b1;
    n = 0;
    repeat (120) begin
      tick(1);
      if (sckInEdge === 1'b1) n++;
    end
    check(16, n);
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    tick(1);
    t_regs();
    t_rx();
    t_tx();
    t_abort();
    t_fault();
    tally_and_finish();
  end
endmodule
